//--- common/epiu_pkg.sv
// package: register map, field layout and reset values of the external pin interrupt unit
package epiu_pkg;
    localparam int EPIU_ADDR_W = 3;
    localparam logic [2:0] EPIU_OFS_SENSE = 3'h0;
    localparam logic [2:0] EPIU_OFS_EXT_MASK = 3'h1;
    localparam logic [2:0] EPIU_OFS_EXT_FLAGS = 3'h2;
    localparam logic [2:0] EPIU_OFS_PC_CTRL = 3'h3;
    localparam logic [2:0] EPIU_OFS_PC_FLAGS = 3'h4;
    localparam logic [2:0] EPIU_OFS_PC_MASK_HI = 3'h5;
    localparam logic [2:0] EPIU_OFS_PC_MASK_LO = 3'h6;
    localparam logic [7:0] EPIU_RST_REG = 8'h00;
    localparam int EPIU_SENSE0_POS = 0;
    localparam int EPIU_SENSE1_POS = 2;
    localparam int EPIU_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        EPIU_SENSE_LOW = 2'h0,
        EPIU_SENSE_ANY = 2'h1,
        EPIU_SENSE_FALL = 2'h2,
        EPIU_SENSE_RISE = 2'h3
    } epiu_sense_type;

    typedef struct packed {
        logic [EPIU_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } epiu_bus_type;

    // per-source requests towards the core: ext pin 0, ext pin 1, group 0, group 1
    typedef struct packed {
        logic group1;
        logic group0;
        logic ext1;
        logic ext0;
    } epiu_req_type;
endpackage : epiu_pkg

//--- rtl/epiu_sync.sv
// two-flop synchroniser for a bank of asynchronous pins
`timescale 1ns/1ps
module epiu_sync
    import epiu_pkg::*;
#(
    parameter int WIDTH = 18
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;
endmodule : epiu_sync

//--- rtl/epiu_edge.sv
// sense decoder for one external interrupt pin
`timescale 1ns/1ps
module epiu_edge
    import epiu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinSync,
    input wire logic [1:0] senseMode,
    output logic edgeHit,
    output logic levelLow
);
    logic prev_ff;
    logic nxt_prev;

    always_comb begin
        nxt_prev = pinSync;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // matches the synchroniser's reset value so release gives no false falling edge
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    always_comb begin
        edgeHit = 1'b0;
        levelLow = 1'b0;
        case (epiu_sense_type'(senseMode))
            EPIU_SENSE_LOW: levelLow = ~pinSync;
            EPIU_SENSE_ANY: edgeHit = pinSync ^ prev_ff;
            EPIU_SENSE_FALL: edgeHit = prev_ff & ~pinSync;
            EPIU_SENSE_RISE: edgeHit = ~prev_ff & pinSync;
            default: edgeHit = 1'b0;
        endcase
    end
endmodule : epiu_edge

//--- rtl/epiu_top.sv
// external pin interrupt unit: sensing, flags, masks and vector requests
//
// Contract
// - ext pin 1 request only while its enable and global interrupt bit are set.
// - ext pin 0 request only while its enable bit 0 and global bit are set.
// - two sense bits per pin pick level or rising, falling or any edge.
// - pin activity triggers even when the pin is driven as output.
// - an edge or change on an ext pin sets that pin's pending flag.
// - flag, enable and global bit together vector the core to that pin.
// - ext flag clears on service acknowledge or software write of one.
// - ext flag stays zero while the pin is level sensed.
// - group 1 requests on unmasked change of pins 15..8 with enable and global.
// - group 0 requests on unmasked change of pins 7..0 with enable and global.
// - group flag bit 1 for pins 15..8, bit 0 for pins 7..0, set on change.
// - group flag plus enables vectors; clears on acknowledge or write one.
// - upper mask bits gate pins 15..8 into group 1.
// - lower mask bits gate pins 7..0 into group 0.
// - unused bits 7..2 (7..4 for sense) read zero; flag and mask registers reset to zero.
// - sense code 00 low, 01 any change, 10 falling, 11 rising.
// - level request stays asserted while the enabled pin is held low.
// - pins are sampled before edge detection; pulses over one clock are caught.
`timescale 1ns/1ps
module epiu_top
    import epiu_pkg::*;
#(
    parameter int CHANGE_PINS = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [EPIU_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [1:0] extPins,
    input wire logic [CHANGE_PINS-1:0] changeInputsUpper,
    input wire logic [CHANGE_PINS-1:0] changeInputsLower,
    input wire logic globalIrqEnable,
    input wire logic [3:0] irqAck,
    output logic [3:0] irqReq
);
    localparam int NPINS = 2 + 2 * CHANGE_PINS;

    epiu_bus_type bus;
    epiu_req_type reqNow;
    logic [NPINS-1:0] pinsSync;
    logic [1:0] extSync;
    logic [CHANGE_PINS-1:0] upperSync;
    logic [CHANGE_PINS-1:0] lowerSync;
    logic [1:0] extEdge;
    logic [1:0] extLevel;

    logic [3:0] sense_ff, nxt_sense;
    logic [1:0] extMask_ff, nxt_extMask;
    logic [1:0] extFlags_ff, nxt_extFlags;
    logic [1:0] pcCtrl_ff, nxt_pcCtrl;
    logic [1:0] pcFlags_ff, nxt_pcFlags;
    logic [CHANGE_PINS-1:0] pcMaskHi_ff, nxt_pcMaskHi;
    logic [CHANGE_PINS-1:0] pcMaskLo_ff, nxt_pcMaskLo;
    logic [CHANGE_PINS-1:0] upperPrev_ff, lowerPrev_ff;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [3:0] req_ff, nxt_req;
    logic [1:0] groupHit;
    logic [1:0] extClr, pcClr;

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // pins are read straight from the pad, not through the port direction logic,
    // so a pin that software drives as output still triggers
    epiu_sync #(
        .WIDTH(NPINS)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({changeInputsUpper, changeInputsLower, extPins}),
        .syncOut(pinsSync)
    );

    assign extSync = pinsSync[1:0];
    assign lowerSync = pinsSync[CHANGE_PINS+1:2];
    assign upperSync = pinsSync[NPINS-1:CHANGE_PINS+2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            epiu_edge u_edge (
                .clk(clk),
                .rst_n(rst_n),
                .pinSync(extSync[gi]),
                .senseMode(sense_ff[2*gi+1:2*gi]),
                .edgeHit(extEdge[gi]),
                .levelLow(extLevel[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upperPrev_ff <= '0;
            lowerPrev_ff <= '0;
        end else begin
            upperPrev_ff <= upperSync;
            lowerPrev_ff <= lowerSync;
        end
    end

    // mask bit cleared means the pin never reaches its group
    always_comb begin
        groupHit[1] = |((upperSync ^ upperPrev_ff) & pcMaskHi_ff);
        groupHit[0] = |((lowerSync ^ lowerPrev_ff) & pcMaskLo_ff);
    end

    // clears from software write-one and from the core's acknowledge
    always_comb begin
        extClr = irqAck[1:0];
        pcClr = irqAck[3:2];
        if (bus.wr && bus.addr == EPIU_OFS_EXT_FLAGS) begin
            extClr = extClr | bus.wdata[1:0];
        end
        if (bus.wr && bus.addr == EPIU_OFS_PC_FLAGS) begin
            pcClr = pcClr | bus.wdata[1:0];
        end
    end

    // register writes and flag updates; a set in the clearing cycle wins
    always_comb begin
        nxt_sense = sense_ff;
        nxt_extMask = extMask_ff;
        nxt_pcCtrl = pcCtrl_ff;
        nxt_pcMaskHi = pcMaskHi_ff;
        nxt_pcMaskLo = pcMaskLo_ff;
        if (bus.wr) begin
            case (bus.addr)
                EPIU_OFS_SENSE: nxt_sense = bus.wdata[3:0];
                EPIU_OFS_EXT_MASK: nxt_extMask = bus.wdata[1:0];
                EPIU_OFS_PC_CTRL: nxt_pcCtrl = bus.wdata[1:0];
                EPIU_OFS_PC_MASK_HI: nxt_pcMaskHi = bus.wdata[CHANGE_PINS-1:0];
                EPIU_OFS_PC_MASK_LO: nxt_pcMaskLo = bus.wdata[CHANGE_PINS-1:0];
                default: nxt_sense = sense_ff;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            nxt_extFlags[i] = extEdge[i] | (extFlags_ff[i] & ~extClr[i]);
            if (sense_ff[2*i+1 -: 2] == EPIU_SENSE_LOW) begin
                nxt_extFlags[i] = 1'b0;
            end
        end
        nxt_pcFlags = groupHit | (pcFlags_ff & ~pcClr);
    end

    // requests: level mode asks directly while the pin stays low
    always_comb begin
        reqNow.ext0 = extMask_ff[0] & globalIrqEnable
                      & (extFlags_ff[0] | extLevel[0]);
        reqNow.ext1 = extMask_ff[1] & globalIrqEnable
                      & (extFlags_ff[1] | extLevel[1]);
        reqNow.group0 = pcCtrl_ff[0] & globalIrqEnable & pcFlags_ff[0];
        reqNow.group1 = pcCtrl_ff[1] & globalIrqEnable & pcFlags_ff[1];
        // drop the request in the acknowledge cycle so it is not taken twice
        nxt_req = reqNow & ~irqAck;
    end

    // read data: unused high bits always read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                EPIU_OFS_SENSE: nxt_rdata = {4'h0, sense_ff};
                EPIU_OFS_EXT_MASK: nxt_rdata = {6'h00, extMask_ff};
                EPIU_OFS_EXT_FLAGS: nxt_rdata = {6'h00, extFlags_ff};
                EPIU_OFS_PC_CTRL: nxt_rdata = {6'h00, pcCtrl_ff};
                EPIU_OFS_PC_FLAGS: nxt_rdata = {6'h00, pcFlags_ff};
                EPIU_OFS_PC_MASK_HI: nxt_rdata = 8'(pcMaskHi_ff);
                EPIU_OFS_PC_MASK_LO: nxt_rdata = 8'(pcMaskLo_ff);
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_ff <= EPIU_RST_REG[3:0];
            extMask_ff <= EPIU_RST_REG[1:0];
            extFlags_ff <= EPIU_RST_REG[1:0];
            pcCtrl_ff <= EPIU_RST_REG[1:0];
            pcFlags_ff <= EPIU_RST_REG[1:0];
            pcMaskHi_ff <= '0;
            pcMaskLo_ff <= '0;
            rdata_ff <= EPIU_RST_REG;
            req_ff <= '0;
        end else begin
            sense_ff <= nxt_sense;
            extMask_ff <= nxt_extMask;
            extFlags_ff <= nxt_extFlags;
            pcCtrl_ff <= nxt_pcCtrl;
            pcFlags_ff <= nxt_pcFlags;
            pcMaskHi_ff <= nxt_pcMaskHi;
            pcMaskLo_ff <= nxt_pcMaskLo;
            rdata_ff <= nxt_rdata;
            req_ff <= nxt_req;
        end
    end

    assign regRdata = rdata_ff;
    assign irqReq = req_ff;
endmodule : epiu_top

//--- tb/epiu_top_properties.sv
// port-level checker of the external pin interrupt unit
`timescale 1ns/1ps
module epiu_checker
    import epiu_pkg::*;
#(
    parameter int CHANGE_PINS = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [EPIU_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic [1:0] extPins,
    input wire logic [CHANGE_PINS-1:0] changeInputsUpper,
    input wire logic [CHANGE_PINS-1:0] changeInputsLower,
    input wire logic globalIrqEnable,
    input wire logic [3:0] irqAck,
    input wire logic [3:0] irqReq
);
    logic [2*CHANGE_PINS+2:0] seen_ff;
    logic [3:0] quiet_ff;
    logic [3:0] nxt_quiet;
    // cycles since the last cause that may raise a request
    always_comb begin
        nxt_quiet = quiet_ff + {3'h0, quiet_ff != 4'hf};
        if ({extPins, changeInputsUpper, changeInputsLower, globalIrqEnable} != seen_ff
            || regWr || |irqAck) begin
            nxt_quiet = 4'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_ff <= 4'h0;
            seen_ff <= '0;
        end else begin
            quiet_ff <= nxt_quiet;
            seen_ff <= {extPins, changeInputsUpper, changeInputsLower, globalIrqEnable};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdIdle; !$past(regRd) |-> regRdata == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data off slot");
    property p_rdResv;
        $past(regRd) && $past(regAddr) inside {3'h1, 3'h2, 3'h3, 3'h4} |-> regRdata[7:2] == 6'h00;
    endproperty
    a_rdResv: assert property (p_rdResv) else $error("unused bits set");
    property p_rdSense; $past(regRd) && $past(regAddr) == 3'h0 |-> regRdata[7:4] == 4'h0; endproperty
    a_rdSense: assert property (p_rdSense) else $error("sense upper bits set");
    property p_rdNone; $past(regRd) && $past(regAddr) == 3'h7 |-> regRdata == 8'h00; endproperty
    a_rdNone: assert property (p_rdNone) else $error("unmapped read data");
    property p_gieOff; !globalIrqEnable |=> irqReq == 4'h0; endproperty
    a_gieOff: assert property (p_gieOff) else $error("request without global");
    property p_ackDrop; |irqAck |=> (irqReq & $past(irqAck)) == 4'h0; endproperty
    a_ackDrop: assert property (p_ackDrop) else $error("request after ack");
    property p_grpHold;
        globalIrqEnable && !regWr && !$past(regWr)
            |=> (($past(irqReq[3:2]) & ~$past(irqAck[3:2])) & ~irqReq[3:2]) == 2'b00;
    endproperty
    a_grpHold: assert property (p_grpHold) else $error("group request lost");
    property p_quiet; quiet_ff >= 4'h6 |-> (irqReq & ~$past(irqReq)) == 4'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("request without cause");
endmodule : epiu_checker
bind epiu_top epiu_checker #(.CHANGE_PINS(CHANGE_PINS)) u_chk (.clk, .rst_n, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .extPins, .changeInputsUpper, .changeInputsLower,
    .globalIrqEnable, .irqAck, .irqReq);

//--- tb/epiu_core_model.sv
// core model: acknowledges each request with a one-cycle pulse
`timescale 1ns/1ps
module epiu_core_model
    import epiu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic autoAck,
    input wire logic [3:0] irqReq,
    output logic [3:0] irqAck
);
    // the request falls the cycle after the ack, so masking avoids a double ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqAck <= 4'h0;
        end else begin
            irqAck <= autoAck ? (irqReq & ~irqAck) : 4'h0;
        end
    end
endmodule : epiu_core_model

//--- tb/tb.sv
// testbench of the external pin interrupt unit
`timescale 1ns/1ps
module tb;
    import epiu_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic [1:0] extPins = 2'h3;
    logic [7:0] upPins = 8'h00;
    logic [7:0] loPins = 8'h00;
    logic gie = 1'b0;
    logic autoAck = 1'b0;
    logic [3:0] irqAck;
    logic [3:0] irqReq;
    int errors = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    epiu_top #(.CHANGE_PINS(8)) dut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .extPins, .changeInputsUpper(upPins), .changeInputsLower(loPins),
        .globalIrqEnable(gie), .irqAck, .irqReq);
    epiu_core_model core (.clk, .rst_n, .autoAck, .irqReq, .irqAck);
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check("regRdata", exp, regRdata);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic t_regs;
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        wr(EPIU_OFS_EXT_MASK, 8'hff);
        rd(EPIU_OFS_EXT_MASK, 8'h03);
        wr(EPIU_OFS_PC_CTRL, 8'hff);
        rd(EPIU_OFS_PC_CTRL, 8'h03);
        wr(EPIU_OFS_SENSE, 8'hff);
        rd(EPIU_OFS_SENSE, 8'h0f);
        wr(EPIU_OFS_EXT_FLAGS, 8'hff);
        rd(EPIU_OFS_EXT_FLAGS, 8'h00);
    endtask : t_regs
    task automatic t_group;
        wr(EPIU_OFS_PC_MASK_LO, 8'h01);
        wr(EPIU_OFS_PC_MASK_HI, 8'h80);
        wr(EPIU_OFS_PC_FLAGS, 8'h03);
        @(posedge clk);
        loPins <= 8'h02;
        upPins <= 8'h80;
        idle(6);
        check("irqReq", 8'h00, {4'h0, irqReq});
        rd(EPIU_OFS_PC_FLAGS, 8'h02);
        @(posedge clk);
        gie <= 1'b1;
        idle(2);
        check("irqReq", 8'h08, {4'h0, irqReq});
        wr(EPIU_OFS_PC_FLAGS, 8'h02);
        idle(2);
        check("irqReq", 8'h00, {4'h0, irqReq});
        @(posedge clk);
        loPins <= 8'h03;
        idle(6);
        check("irqReq", 8'h04, {4'h0, irqReq});
        @(posedge clk);
        autoAck <= 1'b1;
        idle(4);
        check("irqReq", 8'h00, {4'h0, irqReq});
        rd(EPIU_OFS_PC_FLAGS, 8'h00);
        @(posedge clk);
        autoAck <= 1'b0;
    endtask : t_group
    task automatic t_edge;
        logic [1:0] m;
        for (int i = 1; i < 4; i++) begin
            m = i[1:0];
            wr(EPIU_OFS_SENSE, {4'h0, m, m});
            wr(EPIU_OFS_EXT_FLAGS, 8'h03);
            @(posedge clk);
            extPins <= 2'h0;
            idle(6);
            rd(EPIU_OFS_EXT_FLAGS, (m != EPIU_SENSE_RISE) ? 8'h03 : 8'h00);
            check("irqReq", (m != EPIU_SENSE_RISE) ? 8'h03 : 8'h00, {4'h0, irqReq});
            wr(EPIU_OFS_EXT_FLAGS, 8'h03);
            @(posedge clk);
            extPins <= 2'h3;
            idle(6);
            rd(EPIU_OFS_EXT_FLAGS, (m != EPIU_SENSE_FALL) ? 8'h03 : 8'h00);
        end
        @(posedge clk);
        autoAck <= 1'b1;
        idle(4);
        check("irqReq", 8'h00, {4'h0, irqReq});
        rd(EPIU_OFS_EXT_FLAGS, 8'h00);
        @(posedge clk);
        autoAck <= 1'b0;
    endtask : t_edge
    task automatic t_level;
        wr(EPIU_OFS_SENSE, 8'h00);
        wr(EPIU_OFS_EXT_FLAGS, 8'h03);
        @(posedge clk);
        extPins <= 2'h2;
        idle(6);
        check("irqReq", 8'h01, {4'h0, irqReq});
        rd(EPIU_OFS_EXT_FLAGS, 8'h00);
        wr(EPIU_OFS_EXT_MASK, 8'h02);
        idle(2);
        check("irqReq", 8'h00, {4'h0, irqReq});
        @(posedge clk);
        extPins <= 2'h1;
        idle(6);
        check("irqReq", 8'h02, {4'h0, irqReq});
        @(posedge clk);
        extPins <= 2'h3;
        idle(6);
        check("irqReq", 8'h00, {4'h0, irqReq});
    endtask : t_level
    task automatic summarize;
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_group();
        t_edge();
        t_level();
        summarize();
    end
    initial begin
        #20000;
        errors++;
        summarize();
    end
endmodule : tb
